// ---- rtl/asvp_pkg.sv ----
// ----------------------------------------------------------------
// shared constants of the command engine
// ----------------------------------------------------------------
package asvp_pkg;
	// task-file byte addresses
	localparam logic [9:0] ADDR_FEAT_ERR  = 10'h1f1; // feature_in on write, error_out on read
	localparam logic [9:0] ADDR_SEC_CNT   = 10'h1f2; // sector_count
	localparam logic [9:0] ADDR_SEC_NUM   = 10'h1f3; // sector_number
	localparam logic [9:0] ADDR_CYL_LO    = 10'h1f4; // cylinder_low
	localparam logic [9:0] ADDR_CYL_HI    = 10'h1f5; // cylinder_high
	localparam logic [9:0] ADDR_DEV_HEAD  = 10'h1f6; // device_head
	localparam logic [9:0] ADDR_CMD_STAT  = 10'h1f7; // command_in on write, status_out on read
	// command codes
	localparam logic [7:0] CMD_WRITE_VERIFY = 8'h3c; // write with verify
	localparam logic [3:0] CMD_RECAL_HI     = 4'h1;  // recalibrate, low nibble ignored
	localparam logic [3:0] CMD_SEEK_HI      = 4'h7;  // seek, low nibble ignored
	localparam logic [7:0] CMD_SET_GEOMETRY = 8'h91; // set sectors per track and max head
	// status and device_head fields, error_out code
	localparam int         ST_BUSY_BIT  = 7; // busy_bit
	localparam int         ST_READY_BIT = 6; // drive ready
	localparam int         ST_SEEK_BIT  = 4; // seek_complete_flag
	localparam int         ST_ERR_BIT   = 0; // error indication
	localparam int         DH_LBA_BIT   = 6; // addressing mode
	localparam int         DH_UNIT_BIT  = 4; // drive_select_bit
	localparam logic [7:0] ERR_ABORTED  = 8'h04; // aborted command
	// reset values of the task file
	localparam logic [7:0] RST_SEC_CNT  = 8'h01;
	localparam logic [7:0] RST_SEC_NUM  = 8'h01;
	localparam logic [7:0] RST_ZERO     = 8'h00;
	// address divider length, one step per lba bit
	localparam logic [4:0] DIV_LAST     = 5'h1b;
	// medium operation kinds
	typedef enum logic [1:0] {
		OP_WRITE  = 2'h0,
		OP_VERIFY = 2'h1,
		OP_SEEK   = 2'h2,
		OP_RECAL  = 2'h3
	} asvp_op_t;
	// engine states, one-hot
	typedef enum logic [7:0] {
		ST_IDLE   = 8'h01,
		ST_WRITE  = 8'h02,
		ST_VERIFY = 8'h04,
		ST_DIV    = 8'h08,
		ST_SEEK   = 8'h10,
		ST_RECAL  = 8'h20,
		ST_GEOM   = 8'h40,
		ST_DONE   = 8'h80
	} asvp_state_t;
endpackage

// ---- rtl/asvp_cmd.sv ----
`timescale 1ns/100ps
`default_nettype none
module asvp_cmd
	import asvp_pkg::*;
#(
	parameter logic [7:0] DEF_SPT    = 8'h3f, // default sectors per track
	parameter logic [4:0] DEF_HEADS  = 5'h0f, // default head count
	parameter logic       DRIVE_UNIT = 1'b0   // which drive_unit this is
) (
	input  wire logic        clk,
	input  wire logic        rst_n,       // hard or soft reset
	input  wire logic        pwrOnRst_n,  // power-on only, clears geometry
	input  wire logic [9:0]  regAddr,
	input  wire logic [7:0]  regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output var  logic [7:0]  regRdata,
	output var  logic        hostIrq,     // host_interrupt_line
	output var  logic        opStart,
	output var  asvp_op_t    opKind,
	output var  logic        opLba,
	output var  logic [27:0] opAddr,
	input  wire logic        opDone,
	input  wire logic        opError,
	input  wire logic [7:0]  opErrCode
);
	// ----------------------------------------------------------------
	// task file and engine state
	// ----------------------------------------------------------------
	asvp_state_t state_r;       // engine sequence
	logic [7:0]  secCnt_r;      // sector_count
	logic [7:0]  secNum_r;      // sector_number
	logic [7:0]  cylLo_r;       // cylinder_low
	logic [7:0]  cylHi_r;       // cylinder_high
	logic [7:0]  devHead_r;     // device_head
	logic [7:0]  errCode_r;     // error_out
	logic        errBit_r;      // error indication in status
	logic [7:0]  spt_r;         // stored sectors per track
	logic [3:0]  maxHead_r;     // stored highest head number
	logic [27:0] divNum_r;      // dividend, becomes quotient
	logic [8:0]  divRem_r;      // partial remainder
	logic [4:0]  divCnt_r;      // step counter
	logic        divPass_r;     // 0: by sectors, 1: by heads
	logic [7:0]  divSec_r;      // sector found by first pass
	logic        busy;          // busy_bit
	logic        lbaMode;       // addressing mode bit
	logic [27:0] lba;           // block address from task file
	logic [7:0]  status;        // status_out image
	logic        cmdWr;         // accepted command write
	logic        tfWr;          // accepted task-file write
	logic        mediaDone;     // medium step finished
	logic        mediaFail;     // medium step failed
	logic [8:0]  remShift;      // divider shifted remainder
	logic [8:0]  divDen;        // divider denominator
	logic        remGeq;        // subtract this step
	logic [8:0]  remNext;       // next remainder
	logic [27:0] numNext;       // next dividend
	logic [7:0]  nxtSec;        // next chs sector
	logic [3:0]  nxtHead;       // next chs head
	logic [15:0] nxtCyl;        // next chs cylinder
	logic [27:0] nxtAddr;       // next sector address to write

	assign busy      = (state_r != ST_IDLE);
	assign lbaMode   = devHead_r[DH_LBA_BIT];
	assign lba       = {devHead_r[3:0], cylHi_r, cylLo_r, secNum_r};
	// seek complete held high whatever the engine does
	assign status    = {busy, 1'b1, 1'b0, 1'b1, 3'b000, errBit_r};
	// commands for the other unit are left alone
	assign cmdWr     = regWr && (regAddr == ADDR_CMD_STAT) && !busy
	                   && (devHead_r[DH_UNIT_BIT] == DRIVE_UNIT);
	// the host may not disturb the file while a command runs
	assign tfWr      = regWr && !busy;
	assign mediaDone = opDone && (state_r inside {ST_WRITE, ST_VERIFY, ST_SEEK, ST_RECAL});
	assign mediaFail = mediaDone && opError;

	// ----------------------------------------------------------------
	// restoring divider for lba to chs
	// ----------------------------------------------------------------
	// divide by default geometry so lba seeks stay in the default area
	always_comb begin
		remShift = {divRem_r[7:0], divNum_r[27]};
		divDen   = divPass_r ? {4'h0, DEF_HEADS} : {1'b0, DEF_SPT};
		remGeq   = (remShift >= divDen);
		remNext  = remGeq ? (remShift - divDen) : remShift;
		numNext  = {divNum_r[26:0], remGeq};
	end

	// ----------------------------------------------------------------
	// next sector address for multi-sector writes
	// ----------------------------------------------------------------
	// chs stepping follows the geometry the host set
	always_comb begin
		nxtSec  = secNum_r + 8'h01;
		nxtHead = devHead_r[3:0];
		nxtCyl  = {cylHi_r, cylLo_r};
		if (secNum_r >= spt_r) begin
			nxtSec = RST_SEC_NUM;
			if (devHead_r[3:0] >= maxHead_r) begin
				nxtHead = 4'h0;
				nxtCyl  = nxtCyl + 16'h0001;
			end else begin
				nxtHead = devHead_r[3:0] + 4'h1;
			end
		end
		nxtAddr = lbaMode ? (lba + 28'h0000001) : {nxtHead, nxtCyl, nxtSec};
	end

	// ----------------------------------------------------------------
	// command sequencer and medium requests
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r   <= ST_IDLE;
			opStart   <= 1'b0;
			opKind    <= OP_WRITE;
			opLba     <= 1'b0;
			opAddr    <= 28'h0000000;
			divNum_r  <= 28'h0000000;
			divRem_r  <= 9'h000;
			divCnt_r  <= 5'h00;
			divPass_r <= 1'b0;
			divSec_r  <= 8'h00;
		end else begin
			opStart <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (cmdWr) begin
						if (regWdata == CMD_WRITE_VERIFY) begin
							// first sector goes out as a plain write
							state_r <= ST_WRITE;
							opStart <= 1'b1;
							opKind  <= OP_WRITE;
							opLba   <= lbaMode;
							opAddr  <= lba;
						end else if (regWdata[7:4] == CMD_SEEK_HI) begin
							if (lbaMode) begin
								// convert the block address first
								state_r   <= ST_DIV;
								divNum_r  <= lba;
								divRem_r  <= 9'h000;
								divCnt_r  <= 5'h00;
								divPass_r <= 1'b0;
							end else begin
								// chs seek straight from the file
								state_r <= ST_SEEK;
								opStart <= 1'b1;
								opKind  <= OP_SEEK;
								opLba   <= 1'b0;
								opAddr  <= lba;
							end
						end else if (regWdata[7:4] == CMD_RECAL_HI) begin
							// addressing mode plays no part here
							state_r <= ST_RECAL;
							opStart <= 1'b1;
							opKind  <= OP_RECAL;
							opLba   <= 1'b0;
							opAddr  <= 28'h0000000;
						end else if (regWdata == CMD_SET_GEOMETRY) begin
							// mode bit deliberately not looked at
							state_r <= ST_GEOM;
						end else begin
							// anything else ends at once, aborted
							state_r <= ST_DONE;
						end
					end
				end
				ST_WRITE: begin
					if (opDone) begin
						if (opError) begin
							state_r <= ST_DONE;
						end else begin
							// read-back check, no data on the host side
							state_r <= ST_VERIFY;
							opStart <= 1'b1;
							opKind  <= OP_VERIFY;
						end
					end
				end
				ST_VERIFY: begin
					if (opDone) begin
						if (opError || (secCnt_r == 8'h01)) begin
							state_r <= ST_DONE;
						end else begin
							state_r <= ST_WRITE;
							opStart <= 1'b1;
							opKind  <= OP_WRITE;
							opAddr  <= nxtAddr;
						end
					end
				end
				ST_DIV: begin
					divCnt_r <= divCnt_r + 5'h01;
					divNum_r <= numNext;
					divRem_r <= remNext;
					if (divCnt_r == DIV_LAST) begin
						divCnt_r <= 5'h00;
						if (!divPass_r) begin
							// quotient now divided by heads
							divSec_r  <= remNext[7:0] + 8'h01;
							divRem_r  <= 9'h000;
							divPass_r <= 1'b1;
						end else begin
							// position is {head, cylinder, sector}
							state_r <= ST_SEEK;
							opStart <= 1'b1;
							opKind  <= OP_SEEK;
							opLba   <= 1'b0;
							opAddr  <= {remNext[3:0], numNext[15:0], divSec_r};
						end
					end
				end
				ST_SEEK, ST_RECAL: begin
					if (opDone) begin
						state_r <= ST_DONE;
					end
				end
				ST_GEOM: begin
					state_r <= ST_DONE;
				end
				ST_DONE: begin
					state_r <= ST_IDLE;
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// error indication and error_out
	// ----------------------------------------------------------------
	// a new command starts clean; an unknown code aborts at the command write, other errors arise as it runs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			errBit_r  <= 1'b0;
			errCode_r <= RST_ZERO;
		end else if (cmdWr) begin
			errBit_r  <= 1'b0;
			errCode_r <= RST_ZERO;
			if (!((regWdata == CMD_WRITE_VERIFY) || (regWdata == CMD_SET_GEOMETRY)
			      || (regWdata[7:4] == CMD_SEEK_HI) || (regWdata[7:4] == CMD_RECAL_HI))) begin
				errBit_r  <= 1'b1;
				errCode_r <= ERR_ABORTED;
			end
		end else if (mediaFail) begin
			// verify errors posted like write errors
			errBit_r  <= 1'b1;
			errCode_r <= opErrCode;
		end else if ((state_r == ST_GEOM) && (secCnt_r == RST_ZERO)) begin
			errBit_r  <= 1'b1;
			errCode_r <= ERR_ABORTED;
		end
	end

	// ----------------------------------------------------------------
	// task-file registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			secCnt_r  <= RST_SEC_CNT;
			secNum_r  <= RST_SEC_NUM;
			cylLo_r   <= RST_ZERO;
			cylHi_r   <= RST_ZERO;
			devHead_r <= RST_ZERO;
		end else if (tfWr) begin
			// feature_in is accepted and has no use here
			case (regAddr)
				ADDR_SEC_CNT:  secCnt_r  <= regWdata;
				ADDR_SEC_NUM:  secNum_r  <= regWdata;
				ADDR_CYL_LO:   cylLo_r   <= regWdata;
				ADDR_CYL_HI:   cylHi_r   <= regWdata;
				ADDR_DEV_HEAD: devHead_r <= regWdata;
				default:       secCnt_r  <= secCnt_r;
			endcase
		end else if ((state_r == ST_VERIFY) && opDone && !opError) begin
			// count only drops once a sector passed; failure leaves the rest
			secCnt_r <= secCnt_r - 8'h01;
			if (secCnt_r != 8'h01) begin
				{devHead_r[3:0], cylHi_r, cylLo_r, secNum_r} <= nxtAddr;
			end
		end
	end

	// ----------------------------------------------------------------
	// geometry store
	// ----------------------------------------------------------------
	// only power-on clears it, so host resets keep it
	always_ff @(posedge clk) begin
		if (!pwrOnRst_n) begin
			spt_r     <= DEF_SPT;
			maxHead_r <= 4'(DEF_HEADS - 5'h01);
		end else if ((state_r == ST_GEOM) && (secCnt_r != RST_ZERO)) begin
			spt_r     <= secCnt_r;
			maxHead_r <= devHead_r[3:0];
		end
	end

	// ----------------------------------------------------------------
	// host interrupt
	// ----------------------------------------------------------------
	// raised as busy drops; a status read or new command lowers it, set wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hostIrq <= 1'b0;
		end else if (state_r == ST_DONE) begin
			hostIrq <= 1'b1;
		end else if (cmdWr || (regRd && (regAddr == ADDR_CMD_STAT))) begin
			hostIrq <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read data, one cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			regRdata <= RST_ZERO;
		end else begin
			regRdata <= RST_ZERO;
			if (regRd) begin
				case (regAddr)
					ADDR_FEAT_ERR: regRdata <= errCode_r;
					ADDR_SEC_CNT:  regRdata <= secCnt_r;
					ADDR_SEC_NUM:  regRdata <= secNum_r;
					ADDR_CYL_LO:   regRdata <= cylLo_r;
					ADDR_CYL_HI:   regRdata <= cylHi_r;
					ADDR_DEV_HEAD: regRdata <= devHead_r;
					ADDR_CMD_STAT: regRdata <= status;
					default:       regRdata <= RST_ZERO;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence verifyPassLast;
		(state_r == ST_VERIFY) && opDone && !opError && (secCnt_r == 8'h01);
	endsequence
	sequence seekIssued;
		cmdWr && (regWdata[7:4] == CMD_SEEK_HI);
	endsequence

	seek_flag_one_a: assert property (regRd && (regAddr == ADDR_CMD_STAT) |=> regRdata[ST_SEEK_BIT])
		else $error("seek complete bit read as zero");
	recal_busy_a: assert property (cmdWr && (regWdata[7:4] == CMD_RECAL_HI)
		|=> busy && opStart && (opKind == OP_RECAL))
		else $error("recalibrate did not start");
	busy_irq_a: assert property ($fell(busy) |-> hostIrq)
		else $error("busy dropped without interrupt");
	verify_after_write_a: assert property ((state_r == ST_WRITE) && opDone && !opError
		|=> opStart && (opKind == OP_VERIFY) && (state_r == ST_VERIFY))
		else $error("written sector not verified");
	wv_count_zero_a: assert property (verifyPassLast |=> (secCnt_r == 8'h00) ##1 !busy && hostIrq)
		else $error("sector count not zero at end");
	media_err_a: assert property (mediaFail |=> errBit_r && (errCode_r == $past(opErrCode)) ##1 hostIrq)
		else $error("medium error not posted");
	seek_start_a: assert property (seekIssued |-> ##[1:60] (opStart && (opKind == OP_SEEK)))
		else $error("seek not started in time");
	geo_abort_a: assert property (cmdWr && (regWdata == CMD_SET_GEOMETRY) && (secCnt_r == 8'h00)
		|=> ##1 errBit_r && (errCode_r == ERR_ABORTED) ##1 hostIrq && !busy)
		else $error("zero count geometry not aborted");
	geo_store_a: assert property (cmdWr && (regWdata == CMD_SET_GEOMETRY) && (secCnt_r != 8'h00)
		|=> ##1 (spt_r == $past(secCnt_r, 2)) && !errBit_r)
		else $error("geometry not stored");
	geo_keep_a: assert property (@(posedge clk) disable iff (!pwrOnRst_n)
		!rst_n |=> $stable(spt_r) && $stable(maxHead_r))
		else $error("geometry lost on reset");
endmodule
`default_nettype wire

// ---- verif/asvp_medium.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// medium model: answers each request after a set delay
// ----------------------------------------------------------------
module asvp_medium (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       opStart,   // one request per pulse
	input  var  int         dly,       // cycles from request to answer, at least 1
	input  var  int         failAt,    // request number that reports a fault
	input  wire logic [7:0] errCode,   // fault code handed back
	output var  int         opCount,   // requests seen since reset
	output var  logic       opDone,    // one-cycle answer
	output var  logic       opError,   // fault flag, valid beside opDone only
	output var  logic [7:0] opErrCode  // fault detail, valid beside opDone only
);
	int   left_r; // cycles still to wait
	logic busy_r; // a request is in hand
	logic fail_r; // the request in hand will report a fault
	logic ans;    // answer goes out at this edge

	assign ans = busy_r && (left_r <= 1) && !opStart;

	// ----------------------------------------------------------------
	// request tracking and answer pulse
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_r  <= 1'b0;
			left_r  <= 0;
			fail_r  <= 1'b0;
			opCount <= 0;
			opDone  <= 1'b0;
		end else if (opStart) begin
			// a fault only where the bench asked for one
			busy_r  <= 1'b1;
			left_r  <= dly;
			fail_r  <= (opCount + 1 == failAt);
			opCount <= opCount + 1;
			opDone  <= 1'b0;
		end else if (ans) begin
			busy_r <= 1'b0;
			opDone <= 1'b1;
		end else begin
			left_r <= busy_r ? left_r - 1 : 0;
			opDone <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// fault lines
	// ----------------------------------------------------------------
	// scrambled outside the answer so a design that reads them late is caught
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			opError   <= 1'b0;
			opErrCode <= 8'h00;
		end else if (ans) begin
			opError   <= fail_r;
			opErrCode <= fail_r ? errCode : 8'h00;
		end else begin
			opError   <= ~opError;
			opErrCode <= ~opErrCode;
		end
	end
endmodule
`default_nettype wire

// ---- verif/asvp_cmd_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// command engine bench
// ----------------------------------------------------------------
module asvp_cmd_tb
	import asvp_pkg::*;
;
	// the host reckons lba positions from the default geometry, never from what it set
	localparam int SPT = 63;                 // default sectors per track
	localparam int HDS = 15;                 // default head count
	localparam int LBA = 32'h12345;          // block address for the lba seek
	localparam int SEC = LBA % SPT + 1;      // expected sector
	localparam int HD  = (LBA / SPT) % HDS;  // expected head
	localparam int CYL = LBA / (SPT * HDS);  // expected cylinder
	logic        clk;
	logic        rst_n;
	logic        pwrOnRst_n;
	logic [9:0]  regAddr;
	logic [7:0]  regWdata;
	logic        regWr;
	logic        regRd;
	logic [7:0]  regRdata;
	logic        hostIrq;
	logic        opStart;
	asvp_op_t    opKind;
	logic        opLba;
	logic [27:0] opAddr;
	logic        opDone;
	logic        opError;
	logic [7:0]  opErrCode;
	int          dly;         // medium answer delay
	int          failAt;      // medium request that faults
	logic [7:0]  errCode;     // medium fault code
	int          opCount;     // medium request count
	int          err_count;   // mismatches
	int          comparisons; // compares made
	logic [30:0] opLog[$];    // {lba, kind, address} of each request

	asvp_cmd #(.DEF_SPT(8'h3f), .DEF_HEADS(5'h0f), .DRIVE_UNIT(1'b0)) i_asvp_cmd (
		.clk(clk), .rst_n(rst_n), .pwrOnRst_n(pwrOnRst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.hostIrq(hostIrq), .opStart(opStart), .opKind(opKind), .opLba(opLba),
		.opAddr(opAddr), .opDone(opDone), .opError(opError), .opErrCode(opErrCode));
	asvp_medium i_asvp_medium (
		.clk(clk), .rst_n(rst_n), .opStart(opStart), .dly(dly), .failAt(failAt),
		.errCode(errCode), .opCount(opCount), .opDone(opDone), .opError(opError),
		.opErrCode(opErrCode));

	always #50 clk = ~clk;

	// record every medium request as it leaves
	always @(posedge clk) begin
		if (opStart === 1'b1) begin
			opLog.push_back({opLba, opKind, opAddr});
		end
	end

	// ----------------------------------------------------------------
	// bus and compare tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [30:0] seen, input logic [30:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	// read data stand in the cycle after the strobe only
	task automatic rdChk(input logic [9:0] a, input logic [7:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 check(regRdata, exp);
	endtask
	task automatic setTf(input logic [7:0] cnt, sn, cl, ch, dh);
		wr(ADDR_SEC_CNT, cnt);
		wr(ADDR_SEC_NUM, sn);
		wr(ADDR_CYL_LO, cl);
		wr(ADDR_CYL_HI, ch);
		wr(ADDR_DEV_HEAD, dh);
	endtask
	task automatic issue(input logic [7:0] code);
		opLog.delete();
		wr(ADDR_CMD_STAT, code);
	endtask
	// bounded wait for the interrupt, then status; the read drops it
	task automatic waitDone(input logic [7:0] st);
		int n;
		n = 0;
		while (hostIrq !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		check(hostIrq, 1'b1);
		rdChk(ADDR_CMD_STAT, st);
		check(hostIrq, 1'b0);
	endtask
	task automatic chkOp(input int i, input logic [30:0] e);
		if (i < opLog.size()) check(opLog[i], e);
		else check('x, e);
	endtask
	task automatic results;
		if (err_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	initial begin
		#3000000;
		err_count++;
		results();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 0; rst_n = 0; pwrOnRst_n = 0; regAddr = 0; regWdata = 0; regWr = 0; regRd = 0;
		dly = 1; failAt = 0; errCode = 8'h00; err_count = 0; comparisons = 0;
		repeat (6) @(posedge clk);
		rst_n      <= 1'b1;
		pwrOnRst_n <= 1'b1;
		rdChk(ADDR_CMD_STAT, 8'h50);
		rdChk(10'h1f0, 8'h00);
		// zero sectors per track is refused
		setTf(8'h00, 8'h01, 8'h00, 8'h00, 8'h03);
		issue(CMD_SET_GEOMETRY);
		waitDone(8'h51);
		rdChk(ADDR_FEAT_ERR, ERR_ABORTED);
		// two sectors per track, max head 3, lba bit set and ignored
		setTf(8'h02, 8'h01, 8'h00, 8'h00, 8'h43);
		issue(CMD_SET_GEOMETRY);
		waitDone(8'h50);
		// warm reset keeps the geometry
		@(posedge clk) rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		// two-sector write across a track edge on a slow medium
		dly <= 6;
		setTf(8'h02, 8'h02, 8'h05, 8'h00, 8'h00);
		issue(CMD_WRITE_VERIFY);
		waitDone(8'h50);
		chkOp(0, {1'b0, OP_WRITE, 4'h0, 16'h0005, 8'h02});
		chkOp(1, {1'b0, OP_VERIFY, 4'h0, 16'h0005, 8'h02});
		chkOp(2, {1'b0, OP_WRITE, 4'h1, 16'h0005, 8'h01});
		chkOp(3, {1'b0, OP_VERIFY, 4'h1, 16'h0005, 8'h01});
		rdChk(ADDR_SEC_CNT, 8'h00);
		rdChk(ADDR_DEV_HEAD, 8'h01);
		// lba write whose second verify faults
		dly     <= 1;
		failAt  <= opCount + 4;
		errCode <= 8'h40;
		setTf(8'h03, 8'h64, 8'h00, 8'h00, 8'h40);
		issue(CMD_WRITE_VERIFY);
		waitDone(8'h51);
		rdChk(ADDR_FEAT_ERR, 8'h40);
		rdChk(ADDR_SEC_CNT, 8'h02);
		chkOp(3, {1'b1, OP_VERIFY, 28'h0000065});
		// recalibrate with both ends of the low nibble, lba mode, slow
		dly <= 20;
		setTf(8'h02, 8'h01, 8'h00, 8'h00, 8'h40);
		for (int c = 0; c < 2; c++) begin
			issue({CMD_RECAL_HI, c ? 4'hf : 4'h0});
			rdChk(ADDR_CMD_STAT, 8'hd0);
			waitDone(8'h50);
			chkOp(0, {1'b0, OP_RECAL, 28'h0});
		end
		// seek with both ends of the low nibble, chs addressing
		setTf(8'h02, 8'h11, 8'h34, 8'h12, 8'h05);
		for (int c = 0; c < 2; c++) begin
			issue({CMD_SEEK_HI, c ? 4'hf : 4'h0});
			rdChk(ADDR_CMD_STAT, 8'hd0);
			waitDone(8'h50);
			chkOp(0, {1'b0, OP_SEEK, 4'h5, 16'h1234, 8'h11});
		end
		// failed recalibrate and failed seek
		dly     <= 2;
		errCode <= 8'h02;
		for (int c = 0; c < 2; c++) begin
			failAt <= opCount + 1;
			issue(c ? 8'h7a : 8'h13);
			waitDone(8'h51);
			rdChk(ADDR_FEAT_ERR, 8'h02);
		end
		// lba seek goes to the default geometry position
		setTf(8'h01, 8'h45, 8'h23, 8'h01, 8'h40);
		issue(8'h75);
		waitDone(8'h50);
		chkOp(0, {1'b0, OP_SEEK, HD[3:0], CYL[15:0], SEC[7:0]});
		rdChk(ADDR_SEC_NUM, 8'h45);
		// an unknown code is refused at once with an abort
		issue(8'h00);
		waitDone(8'h51);
		rdChk(ADDR_FEAT_ERR, ERR_ABORTED);
		// a command meant for the other drive unit is left alone
		wr(ADDR_DEV_HEAD, 8'h10);
		issue(CMD_SET_GEOMETRY);
		rdChk(ADDR_CMD_STAT, 8'h51);
		check(hostIrq, 1'b0);
		results();
	end
endmodule
`default_nettype wire
